// *** hdl/pmc_regs.vh ***
// Register offsets, field positions, reset values and timing counts of the power-mode controller
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

// Register offset (byte address of the system power control register)
`define PMC_SYS_POWER_CTRL_OFS   16'hd003
// Offset of the status register, read only
`define PMC_STATUS_OFS           16'hd004
// Offset of the stabilization wait register for interrupt wake from stop
`define PMC_SETTLE_CTRL_OFS      16'hd005

// Field positions in the system power control register
`define PMC_STOP_BIT             0
`define PMC_IDLE_BIT             1
`define PMC_DMA_IDLE_BIT         2
`define PMC_CS_LSB               3
`define PMC_CS_MSB               5
`define PMC_GIE_BIT              6

// Reset values
`define PMC_SYS_POWER_CTRL_RST   8'h00
`define PMC_SETTLE_CTRL_RST      8'h00

// Clock-select codes
`define PMC_CS_DIV16             3'h0
`define PMC_CS_DIV8              3'h1
`define PMC_CS_DIV2              3'h2
`define PMC_CS_DIV1              3'h3
`define PMC_CS_DIV1024           3'h4

// Power-on settle wait: 2^13 x 16 oscillator periods
`define PMC_POR_SETTLE_CYCLES    32'd131072
// Interrupt wake wait unit: settle code n waits (n+1) x this many cycles
`define PMC_SETTLE_UNIT_CYCLES   32'd256

`endif

// *** hdl/pmc_clk_div.v ***
// Master clock divider that issues system clock enable pulses per clock-select code
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.vh"

module pmc_clk_div (
	input  wire       clk,       // Master clock
	input  wire       reset,     // Synchronous reset, active high
	input  wire       ce,        // Clock enable, freezes all state when low
	input  wire       run,       // Oscillator running; divider held when low
	input  wire [2:0] sel,       // Clock-select code
	output reg        tick_q     // One-cycle system clock enable pulse
);

	reg  [9:0] cnt_q;        // Divide counter
	reg  [9:0] limit;        // Terminal count for the selected ratio

	// Divide ratio decode
	always @* begin
		case (sel)
			`PMC_CS_DIV16:   limit = 10'h00f;
			`PMC_CS_DIV8:    limit = 10'h007;
			`PMC_CS_DIV2:    limit = 10'h001;
			`PMC_CS_DIV1:    limit = 10'h000;
			`PMC_CS_DIV1024: limit = 10'h3ff;
			default:         limit = 10'h00f; // Unused codes fall back to the divide-by-16 reset ratio
		endcase
	end

	// A counter left past a new, smaller limit wraps at once, so no long stall
	always @(posedge clk) begin
		if (reset) begin
			cnt_q  <= 10'h000;
			tick_q <= 1'b0;
		end else if (ce) begin
			if (!run) begin
				cnt_q  <= 10'h000;
				tick_q <= 1'b0;
			end else if (cnt_q >= limit) begin
				cnt_q  <= 10'h000;
				tick_q <= 1'b1;
			end else begin
				cnt_q  <= cnt_q + 10'h001;
				tick_q <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// *** hdl/pmc_top.v ***
// Power-mode controller: normal, slow, idle, DMA-idle and stop modes with settle wait
// Behaviour
// - Idle bit gates CPU clock, peripherals run
// - Reset leaving idle restores control defaults
// - Unmasked interrupt releases idle; masked needs reset
// - DMA-idle bit stops CPU clock
// - DMA request wakes CPU, acknowledge resleeps
// - Reset or interrupt also releases DMA-idle
// - Stop bit halts CPU, peripherals, oscillator
// - Stop woken only by reset, external, alarm
// - Reset from stop: defaults, /16, fetch zero
// - Interrupt wake from stop keeps clock select
// - Power-on waits 2^13 x 16 periods
// - Interrupt stop wake uses programmed settle wait
// - Clock-select codes map to documented divide ratios
// - Slow mode divides master clock
// - Bit 6 is global interrupt enable
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.vh"

module pmc_top #(
	parameter POR_SETTLE_CYCLES  = `PMC_POR_SETTLE_CYCLES,  // Power-on settle count
	parameter SETTLE_UNIT_CYCLES = `PMC_SETTLE_UNIT_CYCLES  // Interrupt wake settle unit
) (
	input  wire        clk,             // Master clock, 250 MHz
	input  wire        reset,           // Synchronous reset, active high
	input  wire        ce,              // Clock enable
	input  wire [15:0] addr,            // Register address
	input  wire [7:0]  wdata,           // Write data
	input  wire        wr,              // Write strobe
	input  wire        rd,              // Read strobe
	output reg  [7:0]  rdata_q,         // Read data, valid the cycle after rd
	input  wire        irq_pending,     // Unmasked interrupt active, same domain
	input  wire [11:0] external_irq_lines, // Wake pins from outside
	input  wire        alarm_irq,       // Alarm interrupt, from another domain
	input  wire        dma_req,         // External DMA request pin
	input  wire        dma_ack,         // DMA acknowledge, same domain
	output reg         cpu_clk_en_q,    // CPU clock gate enable
	output reg         periph_clk_en_q, // Peripheral clock enable
	output reg         sys_tick_q,      // System clock enable pulse
	output reg         osc_en_q,        // Main oscillator enable
	output reg         global_irq_gate_q, // Global interrupt enable to controller
	output reg         cpu_restart_q    // Pulse: CPU fetches from address zero
);

	// One-hot mode states
	localparam [5:0] ST_SETTLE_POR = 6'h01; // Power-on settle wait
	localparam [5:0] ST_NORMAL     = 6'h02; // Running (normal or slow)
	localparam [5:0] ST_IDLE       = 6'h04; // CPU clock off
	localparam [5:0] ST_DMA_IDLE   = 6'h08; // CPU off until DMA request
	localparam [5:0] ST_DMA_RUN    = 6'h10; // CPU awake serving DMA
	localparam [5:0] ST_STOP_WAKE  = 6'h20; // Stop or its wake settle

	reg  [5:0]  state_q;       // Mode state
	reg  [7:0]  ctrl_q;        // System power control register
	reg  [7:0]  settle_sel_q;  // Programmed interrupt wake wait
	reg  [31:0] wait_q;        // Settle countdown
	reg         stopped_q;     // Oscillator halted inside stop state
	reg         rst_seen_q;    // Reset occurred; next release is a restart
	reg         first_q;       // Power-on not yet settled
	reg  [2:0]  eirq_s1_q;     // Sync stage one for wake pins, alarm and DMA request
	reg  [2:0]  eirq_s2_q;     // Sync stage two
	reg  [2:0]  eirq_s3_q;     // Sync stage three
	reg         wake_q;        // Filtered wake level
	reg         dreq_q;        // Filtered DMA request level
	wire        tick;          // Divider output
	wire [2:0]  raw_in;        // Asynchronous inputs to synchronise
	wire        ctrl_wr;       // Write to control register
	wire [31:0] irq_wait;      // Interrupt wake settle count

	assign raw_in   = {dma_req, alarm_irq, |external_irq_lines};
	assign ctrl_wr  = wr && (addr == `PMC_SYS_POWER_CTRL_OFS);
	assign irq_wait = ({24'h000000, settle_sel_q} + 32'd1) * SETTLE_UNIT_CYCLES;

	// Checks a requested mode-entry code against what the current state allows
	function legal_entry;
		input [5:0] st;
		input [2:0] req;
		begin
			legal_entry = (st == ST_NORMAL) &&
				((req == 3'h1) || (req == 3'h2) || (req == 3'h4));
		end
	endfunction

	// Three-stage synchronisers; a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
			always @(posedge clk) begin
				if (reset) begin
					eirq_s1_q[gi] <= 1'b0;
					eirq_s2_q[gi] <= 1'b0;
					eirq_s3_q[gi] <= 1'b0;
				end else if (ce) begin
					eirq_s1_q[gi] <= raw_in[gi];
					eirq_s2_q[gi] <= eirq_s1_q[gi];
					eirq_s3_q[gi] <= eirq_s2_q[gi];
				end
			end
		end
	endgenerate

	// Filtered levels; they only move when the last two stages agree
	always @(posedge clk) begin
		if (reset) begin
			wake_q <= 1'b0;
			dreq_q <= 1'b0;
		end else if (ce) begin
			if (eirq_s2_q[1:0] == eirq_s3_q[1:0])
				wake_q <= |eirq_s3_q[1:0];
			if (eirq_s2_q[2] == eirq_s3_q[2])
				dreq_q <= eirq_s3_q[2];
		end
	end

	// Register writes and mode state machine
	// Reset clears the control and settle registers; data registers live elsewhere and keep contents
	always @(posedge clk) begin
		if (reset) begin
			ctrl_q        <= `PMC_SYS_POWER_CTRL_RST;
			settle_sel_q  <= `PMC_SETTLE_CTRL_RST;
			rst_seen_q    <= 1'b1;
			cpu_restart_q <= 1'b0;
			if (first_q || (state_q == ST_STOP_WAKE) || (state_q == ST_SETTLE_POR)) begin
				// Reset during stop or before first settle restarts the long wait;
				// a reset held over several edges must not skip the wait it started
				state_q   <= ST_SETTLE_POR;
				wait_q    <= POR_SETTLE_CYCLES;
				stopped_q <= 1'b0;
			end else begin
				state_q   <= ST_NORMAL;
				wait_q    <= 32'd0;
				stopped_q <= 1'b0;
			end
		end else if (ce) begin
			cpu_restart_q <= 1'b0;
			if (wr && (addr == `PMC_SETTLE_CTRL_OFS))
				settle_sel_q <= wdata;
			case (state_q)
				ST_SETTLE_POR: begin
					if (wait_q > 32'd1) begin
						wait_q <= wait_q - 32'd1;
					end else begin
						state_q       <= ST_NORMAL;
						wait_q        <= 32'd0;
						cpu_restart_q <= rst_seen_q;
						rst_seen_q    <= 1'b0;
					end
				end
				ST_NORMAL: begin
					if (ctrl_wr) begin
						// Clock select and interrupt gate always accepted; mode bits checked
						ctrl_q[`PMC_CS_MSB:`PMC_CS_LSB] <= wdata[`PMC_CS_MSB:`PMC_CS_LSB];
						ctrl_q[`PMC_GIE_BIT] <= wdata[`PMC_GIE_BIT];
						if (legal_entry(state_q, wdata[2:0])) begin
							ctrl_q[2:0] <= wdata[2:0];
							if (wdata[`PMC_STOP_BIT]) begin
								state_q   <= ST_STOP_WAKE;
								stopped_q <= 1'b1;
							end else if (wdata[`PMC_IDLE_BIT]) begin
								state_q <= ST_IDLE;
							end else begin
								state_q <= ST_DMA_IDLE;
							end
						end
					end
				end
				ST_IDLE: begin
					if (irq_pending) begin
						state_q <= ST_NORMAL;
						ctrl_q[`PMC_IDLE_BIT] <= 1'b0;
					end
				end
				ST_DMA_IDLE: begin
					if (irq_pending) begin
						state_q <= ST_NORMAL;
						ctrl_q[`PMC_DMA_IDLE_BIT] <= 1'b0;
					end else if (dreq_q) begin
						state_q <= ST_DMA_RUN;
					end
				end
				ST_DMA_RUN: begin
					if (irq_pending) begin
						state_q <= ST_NORMAL;
						ctrl_q[`PMC_DMA_IDLE_BIT] <= 1'b0;
					end else if (dma_ack) begin
						state_q <= ST_DMA_IDLE;
					end
				end
				ST_STOP_WAKE: begin
					if (stopped_q) begin
						// Only wake pins and alarm are seen here; clock select kept
						if (wake_q) begin
							stopped_q <= 1'b0;
							wait_q    <= irq_wait;
						end
					end else if (wait_q > 32'd1) begin
						wait_q <= wait_q - 32'd1;
					end else begin
						state_q <= ST_NORMAL;
						wait_q  <= 32'd0;
						ctrl_q[`PMC_STOP_BIT] <= 1'b0;
					end
				end
				default: begin
					state_q <= ST_NORMAL;
				end
			endcase
		end
	end

	// Clock gating outputs follow mode state
	always @(posedge clk) begin
		if (reset) begin
			cpu_clk_en_q      <= 1'b0;
			periph_clk_en_q   <= 1'b0;
			osc_en_q          <= 1'b1;
			global_irq_gate_q <= 1'b0;
			sys_tick_q        <= 1'b0;
		end else if (ce) begin
			cpu_clk_en_q      <= (state_q == ST_NORMAL) || (state_q == ST_DMA_RUN);
			periph_clk_en_q   <= (state_q != ST_STOP_WAKE) && (state_q != ST_SETTLE_POR);
			osc_en_q          <= !((state_q == ST_STOP_WAKE) && stopped_q);
			global_irq_gate_q <= ctrl_q[`PMC_GIE_BIT];
			sys_tick_q        <= tick;
		end
	end

	// Read port; data stands one cycle after the strobe
	always @(posedge clk) begin
		if (reset) begin
			rdata_q <= 8'h00;
		end else if (ce) begin
			if (rd) begin
				case (addr)
					`PMC_SYS_POWER_CTRL_OFS: rdata_q <= {1'b0, ctrl_q[6:0]};
					`PMC_STATUS_OFS:         rdata_q <= {2'b00, state_q};
					`PMC_SETTLE_CTRL_OFS:    rdata_q <= settle_sel_q;
					default:                 rdata_q <= 8'h00;
				endcase
			end else begin
				rdata_q <= 8'h00;
			end
		end
	end

	// Divider runs while oscillator is up; held during stop
	pmc_clk_div u_div (
		.clk    (clk),
		.reset  (reset),
		.ce     (ce),
		.run    (osc_en_q),
		.sel    (ctrl_q[`PMC_CS_MSB:`PMC_CS_LSB]),
		.tick_q (tick)
	);

	// Power-on flag, cleared when the first settle completes
	always @(posedge clk) begin
		if (ce && !reset && (state_q == ST_NORMAL))
			first_q <= 1'b0;
	end
	initial first_q = 1'b1;

endmodule
`default_nettype wire

// *** bench/pmc_top_sva.sv ***
// Port checker for the power-mode controller
`timescale 1ns/1ps
`default_nettype none
module pmc_top_sva (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic [15:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [7:0]  rdata_q,
	input wire logic [11:0] external_irq_lines,
	input wire logic        alarm_irq,
	input wire logic        cpu_clk_en_q,
	input wire logic        periph_clk_en_q,
	input wire logic        osc_en_q,
	input wire logic        global_irq_gate_q,
	input wire logic        cpu_restart_q
);
	logic [3:0] stop_age_q; // Cycles since a stop request
	logic [3:0] wake_age_q; // Cycles since a wake pin or the alarm was active
	logic       ctl_wr_q;   // Control write seen last edge
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Ages saturate so a long quiet spell never wraps back to small
	always @(posedge clk) begin
		ctl_wr_q <= wr && addr == 16'hd003;
		if (reset || (wr && addr == 16'hd003 && wdata[2:0] == 3'b001)) begin
			stop_age_q <= 4'h0;
		end else if (stop_age_q != 4'hf) begin
			stop_age_q <= stop_age_q + 4'h1;
		end
		if (reset || |external_irq_lines || alarm_irq) begin
			wake_age_q <= 4'h0;
		end else if (wake_age_q != 4'hf) begin
			wake_age_q <= wake_age_q + 4'h1;
		end
	end
	a_stop_clocks_off: assert property (!osc_en_q |-> !cpu_clk_en_q && !periph_clk_en_q)
		else $error("clocks run with oscillator off");
	a_stop_has_cause: assert property ($fell(osc_en_q) |-> stop_age_q < 4'h6)
		else $error("oscillator stopped without a stop request");
	a_wake_has_cause: assert property ($rose(osc_en_q) |-> wake_age_q < 4'hc)
		else $error("stop left without pin or alarm");
	a_settle_holds: assert property ($rose(osc_en_q) |=> !cpu_clk_en_q [*3])
		else $error("cpu clock before settle wait");
	a_restart_pulse: assert property (cpu_restart_q |=> !cpu_restart_q)
		else $error("restart pulse too long");
	a_restart_runs: assert property (cpu_restart_q |-> !cpu_clk_en_q ##[1:4] cpu_clk_en_q)
		else $error("cpu not started after restart");
	a_rdata_quiet: assert property (!$past(rd) |-> rdata_q == 8'h00)
		else $error("read data outside read slot");
	a_gate_by_write: assert property ($changed(global_irq_gate_q) |-> ctl_wr_q || $past(ctl_wr_q))
		else $error("irq gate moved without write");
endmodule
bind pmc_top pmc_top_sva i_pmc_top_sva (.clk(clk), .reset(reset), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
	.external_irq_lines(external_irq_lines), .alarm_irq(alarm_irq),
	.cpu_clk_en_q(cpu_clk_en_q), .periph_clk_en_q(periph_clk_en_q), .osc_en_q(osc_en_q),
	.global_irq_gate_q(global_irq_gate_q), .cpu_restart_q(cpu_restart_q));
`default_nettype wire

// *** bench/pmc_dma_model.sv ***
// External DMA controller model: one single request, acknowledged later
`timescale 1ns/1ps
`default_nettype none
module pmc_dma_model #(
	parameter ACK_DELAY = 8 // Awake cycles before acknowledge
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic go,         // Start one transfer
	input  wire logic cpu_clk_en, // CPU awake
	output var logic  dma_req,    // Request pin
	output var logic  dma_ack     // Acknowledge, one cycle
);
	logic [3:0] cnt_q; // Transfer progress
	// Single requests only; drop the request once served so a stale one cannot rewake
	always @(posedge clk) begin
		dma_ack <= 1'b0;
		if (reset) begin
			dma_req <= 1'b0;
			cnt_q <= 4'h0;
		end else if (go && !dma_req && cnt_q == 4'h0) begin
			dma_req <= 1'b1;
		end else if (dma_req && cpu_clk_en) begin
			dma_req <= 1'b0;
			cnt_q <= 4'h1;
		end else if (cnt_q == ACK_DELAY) begin
			dma_ack <= 1'b1;
			cnt_q <= 4'h0;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench for the power-mode controller
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        ce = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        irq_pending = 1'b0;
	logic [11:0] ext_irq = 12'h000;
	logic        alarm = 1'b0;
	logic        dma_go = 1'b0;
	logic [7:0]  rdata_q;
	logic        cpu_clk_en_q, periph_clk_en_q, sys_tick_q, osc_en_q;
	logic        global_irq_gate_q, cpu_restart_q, dma_req, dma_ack;
	int          n_errors = 0;
	int          tests_run = 0;
	int          n_rst = 0;    // Restart pulses seen
	int          waited;       // Cycles of the last wait
	int          tbl[5] = '{16, 8, 2, 1, 1024}; // Divide per select code
	always #2 clk = ~clk;
	pmc_top #(.POR_SETTLE_CYCLES(16), .SETTLE_UNIT_CYCLES(2)) i_pmc_top (
		.clk(clk), .reset(reset), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata_q(rdata_q), .irq_pending(irq_pending),
		.external_irq_lines(ext_irq), .alarm_irq(alarm), .dma_req(dma_req),
		.dma_ack(dma_ack), .cpu_clk_en_q(cpu_clk_en_q), .periph_clk_en_q(periph_clk_en_q),
		.sys_tick_q(sys_tick_q), .osc_en_q(osc_en_q),
		.global_irq_gate_q(global_irq_gate_q), .cpu_restart_q(cpu_restart_q));
	pmc_dma_model i_pmc_dma_model (.clk(clk), .reset(reset), .go(dma_go),
		.cpu_clk_en(cpu_clk_en_q), .dma_req(dma_req), .dma_ack(dma_ack));
	// Count restart pulses
	always @(posedge clk) begin
		if (cpu_restart_q === 1'b1) n_rst <= n_rst + 1;
	end
	task stop_test;
		$display("mismatches %0d, checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task rd_chk(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata_q, e);
	endtask
	// Bounded wait for the cpu clock gate to reach v
	task wait_on(input logic v);
		for (waited = 0; waited < 3000 && cpu_clk_en_q !== v; waited++) begin
			@(posedge clk);
			#1;
		end
		chk(cpu_clk_en_q, v);
	endtask
	task pulse_reset;
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
	endtask
	// Third tick gap, so a divider finishing an old period is skipped
	task tick_period(input int exp);
		int j, n;
		for (j = 0; j < 3; j++) begin
			n = 0;
			do begin
				@(posedge clk);
				#1;
				n++;
			end while (sys_tick_q !== 1'b1 && n < 3000);
		end
		chk(n, exp);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		wait_on(1'b1);
		chk(waited >= 16, 1);
		chk(n_rst, 1);
		rd_chk(16'hd003, 8'h00);
		rd_chk(16'hd00f, 8'h00);
		$display("power-on test done");
		for (int k = 0; k < 5; k++) begin
			wr_reg(16'hd003, 8'(k << 3));
			tick_period(tbl[k]);
		end
		wr_reg(16'hd003, 8'h4b);
		rd_chk(16'hd004, 8'h02);
		rd_chk(16'hd003, 8'h48);
		chk(global_irq_gate_q, 1'b1);
		$display("select test done");
		wr_reg(16'hd003, 8'h4a);
		wait_on(1'b0);
		chk(periph_clk_en_q, 1'b1);
		irq_pending <= 1'b1;
		wait_on(1'b1);
		irq_pending <= 1'b0;
		rd_chk(16'hd003, 8'h48);
		wr_reg(16'hd003, 8'h0a);
		repeat (30) @(posedge clk);
		wait_on(1'b0);
		pulse_reset;
		wait_on(1'b1);
		rd_chk(16'hd003, 8'h00);
		$display("idle test done");
		wr_reg(16'hd003, 8'h04);
		wait_on(1'b0);
		dma_go <= 1'b1;
		@(posedge clk);
		dma_go <= 1'b0;
		wait_on(1'b1);
		wait_on(1'b0);
		rd_chk(16'hd004, 8'h08);
		irq_pending <= 1'b1;
		wait_on(1'b1);
		irq_pending <= 1'b0;
		rd_chk(16'hd004, 8'h02);
		$display("dma idle test done");
		wr_reg(16'hd005, 8'h01);
		wr_reg(16'hd003, 8'h09);
		repeat (4) @(posedge clk);
		irq_pending <= 1'b1;
		repeat (20) @(posedge clk);
		chk(osc_en_q, 1'b0);
		irq_pending <= 1'b0;
		alarm <= 1'b1;
		wait_on(1'b1);
		alarm <= 1'b0;
		chk(waited >= 4, 1);
		rd_chk(16'hd003, 8'h08);
		wr_reg(16'hd003, 8'h01);
		repeat (4) @(posedge clk);
		ext_irq <= 12'h800;
		wait_on(1'b1);
		ext_irq <= 12'h000;
		// Let the synchronised wake level fall, or the next stop wakes at once
		repeat (6) @(posedge clk);
		wr_reg(16'hd003, 8'h11);
		repeat (4) @(posedge clk);
		chk(osc_en_q, 1'b0);
		pulse_reset;
		wait_on(1'b1);
		chk(n_rst, 2);
		tick_period(16);
		$display("stop test done");
		// Clock enable low freezes the block: this write must not land
		ce <= 1'b0;
		wr_reg(16'hd005, 8'h5a);
		ce <= 1'b1;
		rd_chk(16'hd005, 8'h00);
		$display("freeze test done");
		stop_test;
	end
	// Cut a hang short
	initial begin
		#100000;
		n_errors++;
		stop_test;
	end
endmodule
`default_nettype wire
